/* File: logic/cmp_consts.vh */
/*
 Constants of the compare match unit: register byte offsets on the
 AXI4-Lite bus, field positions, mode codes and reset values.
 Assumes inclusion by the compare unit, its channel module and the checker.
*/
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

// Register byte offsets
`define OFF_CMP_CONTROL 8'h00
`define OFF_CMP_VALUE_LOW 8'h04
`define OFF_CMP_VALUE_HIGH 8'h08
`define OFF_ENH_CMP_CONTROL 8'h0C
`define OFF_ENH_CMP_VALUE_LOW 8'h10
`define OFF_ENH_CMP_VALUE_HIGH 8'h14
`define OFF_TIMER_B_CONTROL 8'h18
`define OFF_IRQ_STATUS 8'h1C
`define OFF_IRQ_ENABLE 8'h20
`define OFF_UNIT_STATUS 8'h24

// Field positions
`define CTRL_IMPL_MASK 8'h3F
`define POS_STD_TIMER_SELECT 3
`define POS_ENH_TIMER_SELECT 6
`define POS_CMP_IRQ_FLAG 0
`define POS_ENH_CMP_IRQ_FLAG 1

// Mode field codes
`define MODE_OFF 4'h0
`define MODE_TOGGLE 4'h2
`define MODE_DRIVE_HIGH 4'h8
`define MODE_DRIVE_LOW 4'h9
`define MODE_SW_IRQ 4'hA
`define MODE_SPECIAL 4'hB
`define MODE_CAPTURE_TOP 2'h1
`define MODE_COMPARE_TOP 2'h2

// Reset values
`define RST_CONTROL 8'h00
`define RST_VALUE 8'h00
`define RST_IRQ 2'h0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: logic/pin_sync.v */
/*
 Three-stage synchroniser for a pin input, with a filtered level and a
 one-cycle rising-edge pulse.
 Assumes the pin is asynchronous to clk; a change is accepted once the
 second and third stages agree.
*/
`timescale 1ns/10ps
module pin_sync (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Pin and result
   input wire pin,
   output reg level_q,
   output reg rise_q
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk) begin
      if (!resetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
         rise_q <= (s2_q == s3_q) && s3_q && !level_q;
      end
   end

endmodule

/* File: logic/cmp_channel.v */
/*
 One compare channel: time base selection, match detection, compare
 output latch, special event and capture prescaler counter.
 Assumes timer counts come from logic on clk and that the mode and
 value inputs come from registers of the parent.
*/
`timescale 1ns/10ps
`include "cmp_consts.vh"
module cmp_channel (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Configuration
   input wire [3:0] mode,
   input wire [15:0] value,
   input wire sel_b,
   input wire ctrl_clear,
   // Time bases and pin side
   input wire [15:0] timer_a,
   input wire [15:0] timer_b,
   input wire io_latch,
   input wire cap_rise,
   // Results
   output wire hit,
   output wire special,
   output reg pin_q,
   output reg own_q,
   output reg [3:0] presc_q
);

   reg eq_q;
   reg latch_q;
   reg latch_d;
   reg own_d;
   wire [15:0] base;
   wire cmp_mode;
   wire eq;

   // Toggle and the 10xx codes are the compare modes
   assign cmp_mode = (mode == `MODE_TOGGLE) ||
      (mode[3:2] == `MODE_COMPARE_TOP);
   assign base = sel_b ? timer_b : timer_a; // RQ1 RQ12
   assign eq = cmp_mode && (base == value); // RQ14
   assign hit = eq && !eq_q; // RQ1
   assign special = hit && (mode == `MODE_SPECIAL); // RQ6

   always @* begin
      latch_d = latch_q;
      own_d = 1'b0;
      if (ctrl_clear) begin
         latch_d = 1'b0; // RQ4
      end else begin
         case (mode)
            `MODE_DRIVE_HIGH: begin
               own_d = 1'b1;
               if (hit) latch_d = 1'b1; // RQ2
            end
            `MODE_DRIVE_LOW: begin
               own_d = 1'b1;
               if (hit) latch_d = 1'b0; // RQ2
            end
            `MODE_TOGGLE: begin
               own_d = 1'b1;
               if (hit) latch_d = !latch_q; // RQ2
            end
            default: begin
               own_d = 1'b0; // RQ5
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         eq_q <= 1'b0;
         latch_q <= 1'b0;
         pin_q <= 1'b0;
         own_q <= 1'b0;
         presc_q <= 4'h0;
      end else begin
         eq_q <= eq;
         latch_q <= latch_d;
         own_q <= own_d;
         pin_q <= own_d ? latch_d : io_latch; // RQ2
         if (mode[3:2] != `MODE_CAPTURE_TOP || ctrl_clear) begin
            presc_q <= 4'h0; // RQ13
         end else if (cap_rise) begin
            presc_q <= presc_q + 4'h1;
         end
      end
   end

endmodule

/* File: logic/timer_compare_match_unit.v */
/*
 Compare match unit with a standard and an enhanced instance, reached
 over an AXI4-Lite slave, with sticky interrupt flags and one level
 interrupt output.
 Assumes timer counts and the port data latch come from logic on clk,
 capture pins are asynchronous, and the timers take the clear pulses.
*/
// Register access over AXI4-Lite and the address map were chosen for this implementation.
// Notes on behaviour
// RQ1 - Compare value is checked against the selected 16-bit timer count.
// RQ2 - Match drives pin high, low, toggles it, or leaves port latch.
// RQ3 - Interrupt flag is set in the cycle the match reaches the pin.
// RQ4 - Writing control to zero forces the compare output latch low.
// RQ5 - Software interrupt mode leaves pin alone; interrupt only if enabled.
// RQ6 - Special event mode pulses a trigger that clears the assigned timer.
// RQ7 - Each instance has its own compare path and its own trigger.
// RQ8 - Software runs the timer synchronously for compare to work.
// RQ9 - Software clears the pin direction bit for output to show.
// RQ10 - Software writes zero then the new mode to switch prescalers.
// RQ11 - Control top two bits read zero; duty bits five-four; mode three-zero. The enhanced control register keeps and reads all eight bits.
// RQ12 - Timer choice per instance comes from the timer select bits.
// RQ13 - Prescaler counter clears when off, not capturing, or reset.
// RQ14 - Match is checked every clock, suppressed outside compare modes.
`timescale 1ns/10ps
`include "cmp_consts.vh"
module timer_compare_match_unit (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Time bases
   input wire [15:0] timer_a,
   input wire [15:0] timer_b,
   output reg timer_a_clear,
   output reg timer_b_clear,
   // Standard instance pin side
   input wire cmp_io_latch,
   input wire cmp_capture_pin,
   output wire compare_out_pin,
   output wire compare_out_own,
   output reg cmp_special_event,
   // Enhanced instance pin side
   input wire enh_io_latch,
   input wire enh_capture_pin,
   output wire enh_compare_out_pin,
   output wire enh_compare_out_own,
   output reg enh_special_event,
   // Interrupt
   output reg irq
);

   // Register file
   reg [7:0] cmp_control_q;
   reg [7:0] cmp_value_low_q;
   reg [7:0] cmp_value_high_q;
   reg [7:0] enh_cmp_control_q;
   reg [7:0] enh_cmp_value_low_q;
   reg [7:0] enh_cmp_value_high_q;
   reg std_timer_select_q;
   reg enh_timer_select_q;
   reg [1:0] irq_status_q;
   reg [1:0] irq_enable_q;
   reg [1:0] irq_status_d;

   // Bus state
   reg aw_full_q;
   reg [7:0] aw_addr_q;
   reg w_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg aw_full_d;
   reg w_full_d;
   reg bvalid_d;
   reg rvalid_d;

   wire aw_take;
   wire w_take;
   wire ar_take;
   wire do_write;
   wire wr_lane0;
   wire [7:0] wbyte;
   wire cmp_ctrl_clear;
   wire enh_ctrl_clear;

   // Channel results
   wire cmp_hit;
   wire cmp_special;
   wire enh_hit;
   wire enh_special;
   wire [3:0] cmp_presc;
   wire [3:0] enh_presc;
   wire cmp_cap_rise;
   wire enh_cap_rise;

   // Known register offsets
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `OFF_CMP_CONTROL, `OFF_CMP_VALUE_LOW, `OFF_CMP_VALUE_HIGH,
            `OFF_ENH_CMP_CONTROL, `OFF_ENH_CMP_VALUE_LOW,
            `OFF_ENH_CMP_VALUE_HIGH, `OFF_TIMER_B_CONTROL,
            `OFF_IRQ_STATUS, `OFF_IRQ_ENABLE, `OFF_UNIT_STATUS:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   // Write strobe for one register of the pending write
   function wr_hit;
      input [7:0] a;
      input [7:0] target;
      input go;
      begin
         wr_hit = go && (a == target);
      end
   endfunction

   // Read data for an offset; unmapped offsets read zero
   function [31:0] rd_mux;
      input [7:0] a;
      begin
         case (a)
            `OFF_CMP_CONTROL:
               rd_mux = {24'h000000, cmp_control_q & `CTRL_IMPL_MASK};
            `OFF_CMP_VALUE_LOW:
               rd_mux = {24'h000000, cmp_value_low_q};
            `OFF_CMP_VALUE_HIGH:
               rd_mux = {24'h000000, cmp_value_high_q};
            `OFF_ENH_CMP_CONTROL:
               rd_mux = {24'h000000, enh_cmp_control_q};
            `OFF_ENH_CMP_VALUE_LOW:
               rd_mux = {24'h000000, enh_cmp_value_low_q};
            `OFF_ENH_CMP_VALUE_HIGH:
               rd_mux = {24'h000000, enh_cmp_value_high_q};
            `OFF_TIMER_B_CONTROL:
               rd_mux = {25'h0000000, enh_timer_select_q, 2'h0,
                  std_timer_select_q, 3'h0};
            `OFF_IRQ_STATUS:
               rd_mux = {30'h00000000, irq_status_q};
            `OFF_IRQ_ENABLE:
               rd_mux = {30'h00000000, irq_enable_q};
            `OFF_UNIT_STATUS:
               rd_mux = {20'h00000, enh_presc, cmp_presc,
                  enh_compare_out_own, enh_compare_out_pin,
                  compare_out_own, compare_out_pin};
            default:
               rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   assign wr_lane0 = do_write && w_strb_q[0];
   assign wbyte = w_data_q[7:0];
   assign cmp_ctrl_clear = wr_hit(aw_addr_q, `OFF_CMP_CONTROL, wr_lane0) &&
      (wbyte & `CTRL_IMPL_MASK) == 8'h00;
   assign enh_ctrl_clear =
      wr_hit(aw_addr_q, `OFF_ENH_CMP_CONTROL, wr_lane0) && wbyte == 8'h00;

   always @* begin
      aw_full_d = do_write ? 1'b0 : (aw_full_q || aw_take);
      w_full_d = do_write ? 1'b0 : (w_full_q || w_take);
      bvalid_d = do_write ? 1'b1 : (s_axi_bvalid && !s_axi_bready);
      rvalid_d = ar_take ? 1'b1 : (s_axi_rvalid && !s_axi_rready);
   end

   // Write channels, taken in either order, answered after both
   always @(posedge clk) begin
      if (!resetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_full_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_awready <= !aw_full_d && !bvalid_d;
         s_axi_wready <= !w_full_d && !bvalid_d;
         if (do_write) begin
            s_axi_bresp <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Read channel, answered one cycle after the address is taken
   always @(posedge clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_rvalid <= rvalid_d;
         s_axi_arready <= !rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= rd_mux({s_axi_araddr[7:2], 2'b00});
            s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ?
               `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Configuration registers
   always @(posedge clk) begin
      if (!resetn) begin
         cmp_control_q <= `RST_CONTROL;
         cmp_value_low_q <= `RST_VALUE;
         cmp_value_high_q <= `RST_VALUE;
         enh_cmp_control_q <= `RST_CONTROL;
         enh_cmp_value_low_q <= `RST_VALUE;
         enh_cmp_value_high_q <= `RST_VALUE;
         std_timer_select_q <= 1'b0;
         enh_timer_select_q <= 1'b0;
         irq_enable_q <= `RST_IRQ;
      end else begin
         if (wr_hit(aw_addr_q, `OFF_CMP_CONTROL, wr_lane0)) begin
            cmp_control_q <= wbyte & `CTRL_IMPL_MASK; // RQ11
         end
         if (wr_hit(aw_addr_q, `OFF_CMP_VALUE_LOW, wr_lane0)) begin
            cmp_value_low_q <= wbyte;
         end
         if (wr_hit(aw_addr_q, `OFF_CMP_VALUE_HIGH, wr_lane0)) begin
            cmp_value_high_q <= wbyte;
         end
         if (wr_hit(aw_addr_q, `OFF_ENH_CMP_CONTROL, wr_lane0)) begin
            enh_cmp_control_q <= wbyte;
         end
         if (wr_hit(aw_addr_q, `OFF_ENH_CMP_VALUE_LOW, wr_lane0)) begin
            enh_cmp_value_low_q <= wbyte;
         end
         if (wr_hit(aw_addr_q, `OFF_ENH_CMP_VALUE_HIGH, wr_lane0)) begin
            enh_cmp_value_high_q <= wbyte;
         end
         if (wr_hit(aw_addr_q, `OFF_TIMER_B_CONTROL, wr_lane0)) begin
            std_timer_select_q <= wbyte[`POS_STD_TIMER_SELECT]; // RQ12
            enh_timer_select_q <= wbyte[`POS_ENH_TIMER_SELECT]; // RQ12
         end
         if (wr_hit(aw_addr_q, `OFF_IRQ_ENABLE, wr_lane0)) begin
            irq_enable_q <= wbyte[1:0];
         end
      end
   end

   // Sticky flags: a match in the clearing cycle keeps its flag set
   always @* begin
      irq_status_d = irq_status_q;
      if (wr_hit(aw_addr_q, `OFF_IRQ_STATUS, wr_lane0)) begin
         irq_status_d = irq_status_q & ~wbyte[1:0];
      end
      if (cmp_hit) begin
         irq_status_d[`POS_CMP_IRQ_FLAG] = 1'b1; // RQ3
      end
      if (enh_hit) begin
         irq_status_d[`POS_ENH_CMP_IRQ_FLAG] = 1'b1; // RQ3
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         irq_status_q <= `RST_IRQ;
         irq <= 1'b0;
         cmp_special_event <= 1'b0;
         enh_special_event <= 1'b0;
         timer_a_clear <= 1'b0;
         timer_b_clear <= 1'b0;
      end else begin
         irq_status_q <= irq_status_d;
         irq <= |(irq_status_d & irq_enable_q); // RQ5
         cmp_special_event <= cmp_special; // RQ7
         enh_special_event <= enh_special; // RQ7
         timer_a_clear <= (cmp_special && !std_timer_select_q) ||
            (enh_special && !enh_timer_select_q); // RQ6 RQ7
         timer_b_clear <= (cmp_special && std_timer_select_q) ||
            (enh_special && enh_timer_select_q); // RQ6 RQ7
      end
   end

   pin_sync u_cmp_cap_sync (
      .clk(clk),
      .resetn(resetn),
      .pin(cmp_capture_pin),
      .level_q(),
      .rise_q(cmp_cap_rise)
   );

   pin_sync u_enh_cap_sync (
      .clk(clk),
      .resetn(resetn),
      .pin(enh_capture_pin),
      .level_q(),
      .rise_q(enh_cap_rise)
   );

   cmp_channel u_cmp (
      .clk(clk),
      .resetn(resetn),
      .mode(cmp_control_q[3:0]),
      .value({cmp_value_high_q, cmp_value_low_q}),
      .sel_b(std_timer_select_q),
      .ctrl_clear(cmp_ctrl_clear),
      .timer_a(timer_a),
      .timer_b(timer_b),
      .io_latch(cmp_io_latch),
      .cap_rise(cmp_cap_rise),
      .hit(cmp_hit),
      .special(cmp_special),
      .pin_q(compare_out_pin),
      .own_q(compare_out_own),
      .presc_q(cmp_presc)
   );

   cmp_channel u_enh (
      .clk(clk),
      .resetn(resetn),
      .mode(enh_cmp_control_q[3:0]),
      .value({enh_cmp_value_high_q, enh_cmp_value_low_q}),
      .sel_b(enh_timer_select_q),
      .ctrl_clear(enh_ctrl_clear),
      .timer_a(timer_a),
      .timer_b(timer_b),
      .io_latch(enh_io_latch),
      .cap_rise(enh_cap_rise),
      .hit(enh_hit),
      .special(enh_special),
      .pin_q(enh_compare_out_pin),
      .own_q(enh_compare_out_own),
      .presc_q(enh_presc)
   );

endmodule

/* File: tb/timer_model.sv */
/*
 Far-side model: the two 16-bit timers that the compare unit watches.
 Assumes the bench steers run and restart on the same clock.
*/
`timescale 1ns/10ps
module timer_model (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Bench control
   input wire run,
   input wire restart,
   // Clear pulses from the unit
   input wire timer_a_clear,
   input wire timer_b_clear,
   // Counts
   output logic [15:0] timer_a,
   output logic [15:0] timer_b
);
   // Counting on clk keeps the synchronised timer mode
   always @(posedge clk) begin
      if (!resetn || restart || timer_a_clear) begin
         timer_a <= 16'h0000;
      end else if (run) begin
         timer_a <= timer_a + 16'h0001;
      end
      if (!resetn || restart || timer_b_clear) begin
         timer_b <= 16'h0000;
      end else if (run) begin
         timer_b <= timer_b + 16'h0001;
      end
   end
endmodule

/* File: tb/cmp_unit_asserts.sv */
/*
 Checker for the standard compare path and the clear pulses.
 Assumes aw and w of a write are taken at the same edge.
*/
`timescale 1ns/10ps
`include "cmp_consts.vh"
module cmp_unit_checker (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Write snoop
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   // Timers and results
   input wire [15:0] timer_a,
   input wire [15:0] timer_b,
   input wire timer_a_clear,
   input wire timer_b_clear,
   input wire cmp_io_latch,
   input wire compare_out_pin,
   input wire compare_out_own,
   input wire cmp_special_event,
   input wire enh_special_event
);
   logic [15:0] val_q;
   logic [3:0] mode_q;
   logic sel_q;
   logic eq_q;
   wire go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_wstrb[0];
   wire eq = (sel_q ? timer_b : timer_a) == val_q;
   wire hit = eq && !eq_q;
   always @(posedge clk) begin
      if (!resetn) begin
         val_q <= 16'h0000;
         mode_q <= 4'h0;
         sel_q <= 1'b0;
         eq_q <= 1'b0;
      end else begin
         eq_q <= eq;
         if (go) begin
            case (s_axi_awaddr)
               `OFF_CMP_CONTROL: mode_q <= s_axi_wdata[3:0];
               `OFF_CMP_VALUE_LOW: val_q[7:0] <= s_axi_wdata[7:0];
               `OFF_CMP_VALUE_HIGH: val_q[15:8] <= s_axi_wdata[7:0];
               `OFF_TIMER_B_CONTROL: sel_q <= s_axi_wdata[3];
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_spec_hit;
      hit && mode_q == `MODE_SPECIAL |=> cmp_special_event;
   endproperty
   a_spec_hit: assert property (p_spec_hit) else $error("no event");
   property p_spec_cause;
      cmp_special_event |-> $past(hit) && $past(mode_q) == `MODE_SPECIAL;
   endproperty
   a_spec_cause: assert property (p_spec_cause) else $error("stray");
   property p_spec_clear;
      cmp_special_event |-> (sel_q ? timer_b_clear : timer_a_clear);
   endproperty
   a_spec_clear: assert property (p_spec_clear) else $error("no clr");
   property p_spec_pulse;
      cmp_special_event |=> !cmp_special_event;
   endproperty
   a_spec_pulse: assert property (p_spec_pulse) else $error("long");
   property p_drive_hi;
      hit && mode_q == `MODE_DRIVE_HIGH |=> compare_out_pin && compare_out_own;
   endproperty
   a_drive_hi: assert property (p_drive_hi) else $error("not high");
   property p_drive_lo;
      hit && mode_q == `MODE_DRIVE_LOW |=> !compare_out_pin;
   endproperty
   a_drive_lo: assert property (p_drive_lo) else $error("not low");
   property p_toggle;
      hit && mode_q == `MODE_TOGGLE |=>
         compare_out_pin != $past(compare_out_pin);
   endproperty
   a_toggle: assert property (p_toggle) else $error("no toggle");
   property p_sw_pin;
      hit && mode_q == `MODE_SW_IRQ |=> !compare_out_own &&
         compare_out_pin == $past(cmp_io_latch);
   endproperty
   a_sw_pin: assert property (p_sw_pin) else $error("pin moved");
   property p_enh_clear;
      enh_special_event |-> timer_a_clear || timer_b_clear;
   endproperty
   a_enh_clear: assert property (p_enh_clear) else $error("no clr");
   property p_clr_cause;
      timer_a_clear |-> cmp_special_event || enh_special_event;
   endproperty
   a_clr_cause: assert property (p_clr_cause) else $error("stray clr");
   c_spec: cover property (hit && mode_q == `MODE_SPECIAL);
   c_toggle: cover property (hit && mode_q == `MODE_TOGGLE);
   c_enh: cover property (enh_special_event);
endmodule
bind timer_compare_match_unit cmp_unit_checker chk (.clk, .resetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .timer_a, .timer_b,
   .timer_a_clear, .timer_b_clear, .cmp_io_latch, .compare_out_pin,
   .compare_out_own, .cmp_special_event, .enh_special_event);

/* File: tb/tb.sv */
/*
 Testbench of the compare match unit: register bus, compare modes,
 interrupt, timer selection and capture prescaler.
 Assumes the timer model as far side and a 200 MHz clock.
*/
`timescale 1ns/10ps
module tb;
   logic clk = 0, resetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, seed = 6, v;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, run = 0, restart = 0;
   logic cmp_io_latch = 0, cmp_capture_pin = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, timer_a_clear, timer_b_clear, compare_out_pin;
   wire compare_out_own, cmp_special_event, enh_special_event, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] timer_a, timer_b;
   int fail_count = 0, cmp_count = 0, sp_a = 0, clr_a = 0, clr_b = 0;
   int sp_b = 0, ca;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [3:0] md[6] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'hA, 4'hB};
   logic [3:0] st[6] = '{4'h3, 4'h2, 4'h3, 4'h2, 4'h5, 4'h0};
   logic lt[6] = '{0, 0, 0, 0, 1, 0};
   logic en[6] = '{1, 1, 1, 1, 0, 1};
   timer_compare_match_unit dut (.clk, .resetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_a,
      .timer_b, .timer_a_clear, .timer_b_clear, .cmp_io_latch,
      .cmp_capture_pin, .compare_out_pin, .compare_out_own,
      .cmp_special_event, .enh_io_latch(cmp_io_latch),
      .enh_capture_pin(cmp_capture_pin), .enh_compare_out_pin(),
      .enh_compare_out_own(), .enh_special_event, .irq);
   timer_model tm (.clk, .resetn, .run, .restart, .timer_a_clear,
      .timer_b_clear, .timer_a, .timer_b);
   initial begin
      forever #2.5 clk = ~clk;
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task chk(input logic [33:0] g, input logic [33:0] e);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bq.push_back(2'h0);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r = 2'h0);
      rq.push_back({r, e});
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask
   task ci(input logic e);
      @(negedge clk);
      chk(34'(irq), 34'(e));
   endtask
   // Restart both timers, set the mode, then let them run
   task step(input logic [7:0] a, input logic [3:0] m);
      run <= 0;
      restart <= 1;
      @(posedge clk);
      restart <= 0;
      wr(a, {28'h0, m});
      run <= 1;
      repeat (40) @(posedge clk);
      run <= 0;
   endtask
   always @(posedge clk) begin
      sp_a += cmp_special_event;
      sp_b += enh_special_event;
      clr_a += timer_a_clear;
      clr_b += timer_b_clear;
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata},
         rq.pop_front());
      if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp),
         34'(bq.pop_front()));
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1;
      for (int a = 0; a <= 36; a += 4) rd(8'(a), 0);
      rd(8'h28, 0, 2'h2);
      $display("register reset test done");
      wr(8'h00, 32'hFF);
      rd(8'h00, 32'h3F);
      wr(8'h0C, 32'hFF);
      rd(8'h0C, 32'hFF);
      v = xs();
      wr(8'h08, v);
      rd(8'h08, {24'h0, v[7:0]});
      wr(8'h0C, 0);
      wr(8'h00, 0);
      v = 32'h10 + xs() % 16;
      wr(8'h04, v);
      wr(8'h08, 0);
      for (int i = 0; i < 6; i++) begin
         cmp_io_latch <= lt[i];
         wr(8'h20, 32'(en[i]));
         step(8'h00, md[i]);
         rd(8'h24, 32'(st[i]));
         rd(8'h1C, 1);
         ci(en[i]);
         wr(8'h20, 1);
         ci(1);
         wr(8'h1C, 1);
         ci(0);
      end
      chk(34'(sp_a != 0 && clr_a != 0), 1);
      $display("compare mode test done");
      step(8'h00, 4'h8);
      wr(8'h00, 0);
      wr(8'h00, 2);
      rd(8'h24, 2);
      wr(8'h00, 0);
      wr(8'h1C, 1);
      $display("control clear test done");
      ca = clr_a;
      wr(8'h18, 32'h40);
      rd(8'h18, 32'h40);
      wr(8'h10, v);
      step(8'h0C, 4'hB);
      rd(8'h1C, 2);
      chk(34'(clr_a == ca && clr_b != 0 && sp_b != 0), 1);
      wr(8'h1C, 2);
      wr(8'h0C, 0);
      $display("enhanced timer select test done");
      wr(8'h00, 0);
      wr(8'h00, 5);
      repeat (3) begin
         cmp_capture_pin <= 1;
         repeat (4) @(posedge clk);
         cmp_capture_pin <= 0;
         repeat (4) @(posedge clk);
      end
      rd(8'h24, 32'h30);
      wr(8'h00, 0);
      rd(8'h24, 0);
      $display("prescaler test done");
      complete_run();
   end
endmodule
